//--- logic/udis_map.svh
// Register map, field positions and timing counts of the USB interrupt status block.
`ifndef UDIS_MAP_SVH
`define UDIS_MAP_SVH
`define UDIS_ADDR_W        8
`define UDIS_OFF_STATUS    8'h18
`define UDIS_OFF_ENABLE    8'h1c
`define UDIS_OFF_CLEAR     8'h20
`define UDIS_OFF_CONTROL   8'h24
`define UDIS_STATUS_RESET  32'h0000_0000
`define UDIS_STATUS_MASK   32'h00ff_fdff
`define UDIS_BIT_EP1_RX    12
`define UDIS_BIT_CTRL_TX   11
`define UDIS_BIT_CTRL_RX   10
`define UDIS_BIT_SETUP     8
`define UDIS_BIT_VBUS      7
`define UDIS_BIT_DMA       6
`define UDIS_BIT_HS        5
`define UDIS_BIT_RESUME    4
`define UDIS_BIT_SUSPEND   3
`define UDIS_BIT_PSEUDO_FRAME_FLAG      2
`define UDIS_BIT_SOF       1
`define UDIS_BIT_BUS_RESET 0
`define UDIS_BIT_OTG_EN    0
`define UDIS_CLK_PERIOD_NS 8
`define UDIS_PSEUDO_FRAME_FLAG_FS_NS    1000000
`define UDIS_PSEUDO_FRAME_FLAG_HS_NS    125000
`define UDIS_SE0_NS        2000000
`define UDIS_PSEUDO_FRAME_FLAG_FS_CYC   (`UDIS_PSEUDO_FRAME_FLAG_FS_NS / `UDIS_CLK_PERIOD_NS)
`define UDIS_PSEUDO_FRAME_FLAG_HS_CYC   (`UDIS_PSEUDO_FRAME_FLAG_HS_NS / `UDIS_CLK_PERIOD_NS)
`define UDIS_SE0_CYC       ((`UDIS_SE0_NS + `UDIS_CLK_PERIOD_NS - 1) / `UDIS_CLK_PERIOD_NS)
`define UDIS_RESP_OKAY     2'h0
`define UDIS_RESP_DECERR   2'h3
`endif

//--- logic/udis_pkg.sv
// Types shared by the USB interrupt status block.
package udis_pkg;
    typedef struct packed {
        logic [6:1] ep_rx;     // Endpoint receive buffer events.
        logic [6:1] ep_tx;     // Endpoint transmit buffer events.
        logic       ctrl_tx;   // Control endpoint transmit buffer event.
        logic       ctrl_rx;   // Control endpoint receive buffer event.
        logic       setup;     // SETUP token received.
        logic       sof;       // Frame start packet received.
        logic       bus_reset; // Bus reset detected.
    } udis_evt_s;
    typedef struct packed {
        logic       high_speed; // Link runs at high speed.
        logic       suspended;  // Bus is in suspend.
        logic [7:0] dma_reason; // Contents of the DMA reason register.
    } udis_link_s;
endpackage

//--- logic/udis_top.sv
// Interrupt status, enable and clear registers with an AXI4-Lite slave.
`timescale 1ns/1ps
`include "udis_map.svh"
module udis_top #(
    parameter int PSEUDO_FRAME_FLAG_FS_CYC = `UDIS_PSEUDO_FRAME_FLAG_FS_CYC,
    parameter int PSEUDO_FRAME_FLAG_HS_CYC = `UDIS_PSEUDO_FRAME_FLAG_HS_CYC,
    parameter int SE0_CYC     = `UDIS_SE0_CYC
) (
    input  wire udis_pkg::udis_evt_s  evt,    // One-cycle event pulses.
    input  wire udis_pkg::udis_link_s link,   // Link state levels.
    input  wire logic              vbus_pin,    // Bus supply sense pin.
    input  wire logic              dp_pin,      // Data plus line level.
    input  wire logic              dm_pin,      // Data minus line level.
    output logic                   irq,         // Interrupt, active high.
    input  wire logic              aclk,        // Clock.
    input  wire logic              aresetn,     // Synchronous reset, active low.
    input  wire logic [7:0]        s_awaddr,    // Write address.
    input  wire logic              s_awvalid,   // Write address valid.
    output logic                   s_awready,   // Write address ready.
    input  wire logic [31:0]       s_wdata,     // Write data.
    input  wire logic [3:0]        s_wstrb,     // Write byte strobes.
    input  wire logic              s_wvalid,    // Write data valid.
    output logic                   s_wready,    // Write data ready.
    output logic [1:0]             s_bresp,     // Write response.
    output logic                   s_bvalid,    // Write response valid.
    input  wire logic              s_bready,    // Write response ready.
    input  wire logic [7:0]        s_araddr,    // Read address.
    input  wire logic              s_arvalid,   // Read address valid.
    output logic                   s_arready,   // Read address ready.
    output logic [31:0]            s_rdata,     // Read data.
    output logic [1:0]             s_rresp,     // Read response.
    output logic                   s_rvalid,    // Read data valid.
    input  wire logic              s_rready     // Read data ready.
);
    // ****************************************
    // Pin synchronisers and edge detection.
    // ****************************************
    logic [2:0] vbus_q;
    logic [1:0] dp_q;
    logic [1:0] dm_q;
    logic       hs_q;
    logic       suspend_flag_q;
    logic [7:0] dma_q;

    // The third supply stage holds the previous synchronised level for the edge detector.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vbus_q <= 3'h0;
            dp_q   <= 2'h0;
            dm_q   <= 2'h0;
            hs_q   <= 1'h0;
            suspend_flag_q <= 1'h0;
            dma_q  <= 8'h00;
        end else begin
            vbus_q <= {vbus_q[1:0], vbus_pin};
            dp_q   <= {dp_q[0], dp_pin};
            dm_q   <= {dm_q[0], dm_pin};
            hs_q   <= link.high_speed;
            suspend_flag_q <= link.suspended;
            dma_q  <= link.dma_reason;
        end
    end

    wire vbus_rise = vbus_q[1] & ~vbus_q[2];
    wire hs_rise   = link.high_speed & ~hs_q & ~link.suspended;
    wire suspend_flag_rise = link.suspended & ~suspend_flag_q;
    wire suspend_flag_fall = ~link.suspended & suspend_flag_q;
    wire dma_chg   = link.dma_reason != dma_q;
    wire se0       = ~dp_q[1] & ~dm_q[1];

    // ****************************************
    // Pseudo frame timer and single-ended zero timer.
    // ****************************************
    logic [16:0] pseudo_frame_flag_cnt_q;
    logic [17:0] se0_cnt_q;
    logic        otg_en_q;

    // The period follows the present speed, so a speed change applies at once.
    wire [16:0] pseudo_frame_flag_lim  = link.high_speed ? 17'(PSEUDO_FRAME_FLAG_HS_CYC - 1) : 17'(PSEUDO_FRAME_FLAG_FS_CYC - 1);
    wire        pseudo_frame_flag_tick = pseudo_frame_flag_cnt_q >= pseudo_frame_flag_lim;
    wire        se0_hit   = otg_en_q & se0 & (se0_cnt_q == 18'(SE0_CYC - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pseudo_frame_flag_cnt_q <= 17'h0;
            se0_cnt_q  <= 18'h0;
        end else begin
            pseudo_frame_flag_cnt_q <= pseudo_frame_flag_tick ? 17'h0 : pseudo_frame_flag_cnt_q + 17'h1;
            // The counter saturates so that a long SE0 reports once, and it rearms when SE0 ends.
            if (!(otg_en_q & se0))
                se0_cnt_q <= 18'h0;
            else if (se0_cnt_q != 18'(SE0_CYC))
                se0_cnt_q <= se0_cnt_q + 18'h1;
        end
    end

    // ****************************************
    // Event vector.
    // ****************************************
    logic [31:0] set_vec;
    always_comb begin
        set_vec = 32'h0;
        for (int i = 1; i <= 6; i++) begin
            set_vec[`UDIS_BIT_EP1_RX + 2*(i-1)]     = evt.ep_rx[i];
            set_vec[`UDIS_BIT_EP1_RX + 2*(i-1) + 1] = evt.ep_tx[i];
        end
        set_vec[`UDIS_BIT_CTRL_TX]   = evt.ctrl_tx;
        set_vec[`UDIS_BIT_CTRL_RX]   = evt.ctrl_rx;
        set_vec[`UDIS_BIT_SETUP]     = evt.setup;
        set_vec[`UDIS_BIT_VBUS]      = vbus_rise;
        set_vec[`UDIS_BIT_DMA]       = dma_chg;
        set_vec[`UDIS_BIT_HS]        = hs_rise;
        set_vec[`UDIS_BIT_RESUME]    = suspend_flag_fall;
        set_vec[`UDIS_BIT_SUSPEND]   = suspend_flag_rise;
        set_vec[`UDIS_BIT_PSEUDO_FRAME_FLAG]      = pseudo_frame_flag_tick;
        set_vec[`UDIS_BIT_SOF]       = evt.sof;
        // In on-the-go mode the SE0 timer replaces the bus reset source of bit 0.
        set_vec[`UDIS_BIT_BUS_RESET] = otg_en_q ? se0_hit : evt.bus_reset;
    end

    // ****************************************
    // AXI4-Lite write channel.
    // ****************************************
    logic        aw_full_q;
    logic        w_full_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic [31:0] status_q;
    logic [31:0] enable_q;

    // Address and data may come in either order; each is held until its partner arrives.
    assign s_awready = ~aw_full_q & ~bvalid_q;
    assign s_wready  = ~w_full_q & ~bvalid_q;
    wire aw_take = s_awvalid & s_awready;
    wire w_take  = s_wvalid & s_wready;
    wire [7:0]  wr_addr = aw_full_q ? awaddr_q : s_awaddr;
    wire [31:0] wr_data = w_full_q ? wdata_q : s_wdata;
    wire [3:0]  wr_strb = w_full_q ? wstrb_q : s_wstrb;
    wire        wr_go   = (aw_full_q | aw_take) & (w_full_q | w_take);
    wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [31:0] wr_bits = wr_data & wr_mask;
    wire sel_status  = wr_addr == `UDIS_OFF_STATUS;
    wire sel_enable  = wr_addr == `UDIS_OFF_ENABLE;
    wire sel_clear   = wr_addr == `UDIS_OFF_CLEAR;
    wire sel_control = wr_addr == `UDIS_OFF_CONTROL;
    wire wr_known    = sel_status | sel_enable | sel_clear | sel_control;
    wire [31:0] clr_vec = (wr_go & (sel_status | sel_clear)) ? wr_bits : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'h0;
            w_full_q  <= 1'h0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'h0;
            bresp_q   <= `UDIS_RESP_OKAY;
        end else begin
            if (aw_take)
                awaddr_q <= s_awaddr;
            if (w_take) begin
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
            aw_full_q <= wr_go ? 1'h0 : (aw_full_q | aw_take);
            w_full_q  <= wr_go ? 1'h0 : (w_full_q | w_take);
            if (wr_go) begin
                bvalid_q <= 1'h1;
                bresp_q  <= wr_known ? `UDIS_RESP_OKAY : `UDIS_RESP_DECERR;
            end else if (s_bready)
                bvalid_q <= 1'h0;
        end
    end
    assign s_bvalid = bvalid_q;
    assign s_bresp  = bresp_q;

    // ****************************************
    // Registers.
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= `UDIS_STATUS_RESET;
            enable_q <= 32'h0;
            otg_en_q <= 1'h0;
        end else begin
            // A same-cycle event beats the clear so that no event is lost.
            status_q <= ((status_q & ~clr_vec) | set_vec) & `UDIS_STATUS_MASK;
            if (wr_go & sel_enable)
                enable_q <= ((enable_q & ~wr_mask) | wr_bits) & `UDIS_STATUS_MASK;
            if (wr_go & sel_control & wr_strb[0])
                otg_en_q <= wr_data[`UDIS_BIT_OTG_EN];
        end
    end

    assign irq = |(status_q & enable_q);

    // ****************************************
    // AXI4-Lite read channel.
    // ****************************************
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    assign s_arready = ~rvalid_q;
    wire ar_take = s_arvalid & s_arready;
    wire rd_status  = s_araddr == `UDIS_OFF_STATUS;
    wire rd_enable  = s_araddr == `UDIS_OFF_ENABLE;
    wire rd_clear   = s_araddr == `UDIS_OFF_CLEAR;
    wire rd_control = s_araddr == `UDIS_OFF_CONTROL;
    // Unmapped reads return zero together with a decode error response.
    wire [31:0] rd_val = rd_status ? status_q :
                         rd_enable ? enable_q :
                         rd_control ? {31'h0, otg_en_q} : 32'h0;
    wire rd_known = rd_status | rd_enable | rd_clear | rd_control;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'h0;
            rdata_q  <= 32'h0;
            rresp_q  <= `UDIS_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'h1;
            rdata_q  <= rd_val;
            rresp_q  <= rd_known ? `UDIS_RESP_OKAY : `UDIS_RESP_DECERR;
        end else if (s_rready)
            rvalid_q <= 1'h0;
    end
    assign s_rvalid = rvalid_q;
    assign s_rdata  = rdata_q;
    assign s_rresp  = rresp_q;

    // ****************************************
    // Checks.
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_status_write;
        wr_go & sel_status & (wr_strb == 4'hf);
    endsequence
    sequence s_resp_due;
        ##1 s_bvalid;
    endsequence
    sequence s_clear_write;
        wr_go & sel_clear;
    endsequence

    chk_ep_flag_set: assert property (evt.ep_tx[3] |=> status_q[17])
        else $error("endpoint 3 tx flag not set");
    chk_ctrl_flag_set: assert property (evt.ctrl_rx |=> status_q[10])
        else $error("control rx flag not set");
    chk_setup_flag: assert property (evt.setup |=> status_q[8])
        else $error("setup flag not set");
    chk_reserved_bit: assert property (!status_q[9])
        else $error("reserved bit set");
    chk_vbus_edge: assert property (!vbus_q[2] && vbus_q[1] |=> status_q[7])
        else $error("bus supply rise not flagged");
    chk_dma_change: assert property ($changed(link.dma_reason) |=> status_q[6])
        else $error("dma change not flagged");
    chk_hs_suspend: assert property ($rose(link.high_speed) && link.suspended && !status_q[5]
            && !(wr_go && clr_vec[5]) |=> !status_q[5])
        else $error("speed change in suspend flagged");
    chk_suspend_pair: assert property ($fell(link.suspended) |=> status_q[4])
        else $error("resume not flagged");
    chk_pseudo_frame_flag_period: assert property (pseudo_frame_flag_tick |=> !pseudo_frame_flag_tick [*8])
        else $error("pseudo frame ticks too close");
    chk_otg_mask: assert property (otg_en_q && evt.bus_reset && !se0_hit && !status_q[0]
            && !clr_vec[0] |=> !status_q[0])
        else $error("bus reset flagged in otg mode");
    chk_w1c_clear: assert property (s_status_write and (!set_vec[12] && wr_bits[12])
            |=> !status_q[12])
        else $error("write one did not clear");
    chk_set_wins: assert property (clr_vec[1] && evt.sof |=> status_q[1])
        else $error("same-cycle set lost");
    chk_irq_level: assert property (status_q[1] && enable_q[1] |-> irq)
        else $error("irq low with an enabled flag set");
    chk_irq_quiet: assert property ((status_q & enable_q) == 32'h0 |-> !irq)
        else $error("irq high with no enabled flag");
    chk_suspend_flag: assert property ($rose(link.suspended) |=> status_q[3])
        else $error("suspend not flagged");
    chk_hs_flag: assert property ($rose(link.high_speed) && !link.suspended |=> status_q[5])
        else $error("high speed change not flagged");
    chk_sof_flag: assert property (evt.sof |=> status_q[1])
        else $error("frame start not flagged");
    chk_bus_reset: assert property (!otg_en_q && evt.bus_reset |=> status_q[0])
        else $error("bus reset not flagged");
    chk_se0_flag: assert property (se0_hit |=> status_q[0])
        else $error("long SE0 not flagged");
    chk_w1c_keep: assert property (s_clear_write ##0 (status_q[12] && !wr_bits[12])
            |=> status_q[12])
        else $error("write zero cleared a flag");
    chk_rx_even: assert property (evt.ep_rx[1] |=> status_q[12])
        else $error("endpoint 1 rx flag not set");
    chk_write_resp: assert property (wr_go |-> s_resp_due)
        else $error("write response missing");

    // ****************************************
    // Read channel checks.
    // ****************************************
    chk_read_resp: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read response missing");
    chk_read_decerr: assert property (s_arvalid && s_arready && !rd_known |=> s_rresp == `UDIS_RESP_DECERR)
        else $error("unmapped read not refused");
endmodule

//--- tb/udis_host_model.sv
// AXI4-Lite master model standing in for the processor firmware.
`timescale 1ns/1ps
module udis_host_model (
    input  wire logic        aclk,      // Clock.
    output logic [7:0]       s_awaddr,  // Write address.
    output logic             s_awvalid, // Write address valid.
    input  wire logic        s_awready, // Write address ready.
    output logic [31:0]      s_wdata,   // Write data.
    output logic [3:0]       s_wstrb,   // Write byte strobes.
    output logic             s_wvalid,  // Write data valid.
    input  wire logic        s_wready,  // Write data ready.
    input  wire logic [1:0]  s_bresp,   // Write response.
    input  wire logic        s_bvalid,  // Write response valid.
    output logic             s_bready,  // Write response ready.
    output logic [7:0]       s_araddr,  // Read address.
    output logic             s_arvalid, // Read address valid.
    input  wire logic        s_arready, // Read address ready.
    input  wire logic [31:0] s_rdata,   // Read data.
    input  wire logic [1:0]  s_rresp,   // Read response.
    input  wire logic        s_rvalid,  // Read data valid.
    output logic             s_rready   // Read data ready.
);
    initial begin
        {s_awaddr, s_awvalid, s_wdata, s_wvalid, s_bready, s_araddr, s_arvalid, s_rready} = '0;
        s_wstrb = 4'hf;
    end

    // Writing ones clears flags, so firmware writes only the bits it has serviced.
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st, output logic [1:0] r);
        bit aw_done;
        bit w_done;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= v;
        s_wstrb <= st;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        aw_done = 0;
        w_done = 0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_awready) begin
                aw_done = 1;
                s_awvalid <= 1'b0;
            end
            if (!w_done && s_wready) begin
                w_done = 1;
                s_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_bvalid);
        r = s_bresp;
        s_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge aclk); while (!s_arready);
        s_arvalid <= 1'b0;
        while (!s_rvalid) @(posedge aclk);
        v = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
    endtask
endmodule

//--- tb/usb_device_interrupt_status_tb_top.sv
// Self-checking testbench of the USB interrupt status block.
`timescale 1ns/1ps
`include "udis_map.svh"
module usb_device_interrupt_status_tb_top;
    localparam logic [31:0] M = 32'hffff_fffb;
    localparam logic [31:0] A = 32'hffff_ffff;
    localparam int          PSEUDO_FRAME_FLAG_FS = 40;
    localparam int          PSEUDO_FRAME_FLAG_HS = 20;
    logic                 aclk, aresetn, vbus_pin, dp_pin, dm_pin, irq;
    udis_pkg::udis_evt_s  evt;
    udis_pkg::udis_link_s link;
    logic [7:0]           s_awaddr, s_araddr;
    logic [31:0]          s_wdata, s_rdata, d;
    logic [3:0]           s_wstrb;
    logic [1:0]           s_bresp, s_rresp, r;
    logic                 s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic                 s_arvalid, s_arready, s_rvalid, s_rready;
    int                   errors = 0;
    int                   compares = 0;

    udis_top #(.PSEUDO_FRAME_FLAG_FS_CYC(PSEUDO_FRAME_FLAG_FS), .PSEUDO_FRAME_FLAG_HS_CYC(PSEUDO_FRAME_FLAG_HS), .SE0_CYC(30)) i_udis_top (
        .evt(evt), .link(link), .vbus_pin(vbus_pin), .dp_pin(dp_pin), .dm_pin(dm_pin), .irq(irq),
        .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready)
    );
    udis_host_model i_udis_host_model (
        .aclk(aclk), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready)
    );

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic give_verdict;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_udis_host_model.wr(a, v, 4'hf, r);
        check({30'h0, r}, {30'h0, `UDIS_RESP_OKAY});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        i_udis_host_model.rd(a, d, r);
        check(d & m, e);
        check({30'h0, r}, {30'h0, `UDIS_RESP_OKAY});
    endtask

    task automatic pulse(input int i);
        @(posedge aclk);
        evt <= 17'h1 << i;
        @(posedge aclk);
        evt <= '0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    function automatic int pos(input int i);
        if (i >= 11) return 12 + 2 * (i - 11);
        if (i >= 5) return 13 + 2 * (i - 5);
        return (i == 4) ? 11 : (i == 3) ? 10 : (i == 2) ? 8 : i;
    endfunction

    task automatic t_reset;
        i_udis_host_model.wr(8'h40, A, 4'hf, r);
        check({30'h0, r}, {30'h0, `UDIS_RESP_DECERR});
        rdc(`UDIS_OFF_STATUS, M, 32'h0);
        rdc(`UDIS_OFF_ENABLE, A, 32'h0);
        i_udis_host_model.rd(8'h40, d, r);
        check(d, 32'h0);
        check({30'h0, r}, {30'h0, `UDIS_RESP_DECERR});
        $display("test reset done");
    endtask

    task automatic t_events;
        for (int i = 0; i < 17; i++) begin
            pulse(i);
            rdc(`UDIS_OFF_STATUS, M, 32'h1 << pos(i));
            wr(`UDIS_OFF_CLEAR, 32'h0);
            rdc(`UDIS_OFF_STATUS, M, 32'h1 << pos(i));
            rdc(`UDIS_OFF_CLEAR, A, 32'h0);
            wr(`UDIS_OFF_STATUS, 32'h1 << pos(i));
            rdc(`UDIS_OFF_STATUS, M, 32'h0);
        end
        $display("test events done");
    endtask

    task automatic t_link;
        vbus_pin <= 1'b1;
        idle(8);
        rdc(`UDIS_OFF_STATUS, M, 32'h80);
        wr(`UDIS_OFF_CLEAR, A);
        vbus_pin <= 1'b0;
        idle(8);
        rdc(`UDIS_OFF_STATUS, M, 32'h0);
        link.dma_reason <= 8'h05;
        idle(2);
        rdc(`UDIS_OFF_STATUS, M, 32'h40);
        link.dma_reason <= 8'h00;
        idle(2);
        wr(`UDIS_OFF_CLEAR, 32'h40);
        rdc(`UDIS_OFF_STATUS, M, 32'h0);
        link.high_speed <= 1'b1;
        idle(2);
        rdc(`UDIS_OFF_STATUS, M, 32'h20);
        wr(`UDIS_OFF_CLEAR, A);
        link.suspended <= 1'b1;
        idle(2);
        link.high_speed <= 1'b0;
        idle(2);
        link.high_speed <= 1'b1;
        idle(2);
        rdc(`UDIS_OFF_STATUS, M, 32'h08);
        wr(`UDIS_OFF_CLEAR, A);
        link.suspended <= 1'b0;
        idle(2);
        rdc(`UDIS_OFF_STATUS, M, 32'h10);
        wr(`UDIS_OFF_CLEAR, A);
        $display("test link done");
    endtask

    task automatic t_irq;
        wr(`UDIS_OFF_ENABLE, 32'h2);
        rdc(`UDIS_OFF_ENABLE, A, 32'h2);
        pulse(1);
        idle(1);
        #1 check({31'h0, irq}, 32'h1);
        wr(`UDIS_OFF_ENABLE, 32'h0);
        #1 check({31'h0, irq}, 32'h0);
        wr(`UDIS_OFF_ENABLE, 32'h2);
        #1 check({31'h0, irq}, 32'h1);
        wr(`UDIS_OFF_CLEAR, 32'h2);
        #1 check({31'h0, irq}, 32'h0);
        $display("test irq done");
    endtask

    task automatic t_otg;
        wr(`UDIS_OFF_CONTROL, 32'h1);
        rdc(`UDIS_OFF_CONTROL, A, 32'h1);
        pulse(0);
        rdc(`UDIS_OFF_STATUS, M, 32'h0);
        dp_pin <= 1'b0;
        idle(36);
        dp_pin <= 1'b1;
        idle(4);
        rdc(`UDIS_OFF_STATUS, M, 32'h1);
        wr(`UDIS_OFF_CLEAR, A);
        wr(`UDIS_OFF_CONTROL, 32'h0);
        $display("test otg done");
    endtask

    task automatic t_pseudo_frame_flag;
        time t1;
        wr(`UDIS_OFF_ENABLE, 32'h4);
        for (int sp = 1; sp >= 0; sp--) begin
            link.high_speed <= sp[0];
            wr(`UDIS_OFF_CLEAR, 32'h4);
            idle(sp ? 22 : 42);
            rdc(`UDIS_OFF_STATUS, 32'h4, 32'h4);
            wr(`UDIS_OFF_CLEAR, 32'h4);
            while (irq !== 1'b1) @(posedge aclk);
            t1 = $time;
            wr(`UDIS_OFF_CLEAR, 32'h4);
            while (irq !== 1'b1) @(posedge aclk);
            check(32'(($time - t1) / `UDIS_CLK_PERIOD_NS), sp ? PSEUDO_FRAME_FLAG_HS : PSEUDO_FRAME_FLAG_FS);
        end
        wr(`UDIS_OFF_ENABLE, 32'h0);
        $display("test pseudo_frame_flag done");
    endtask

    task automatic t_race;
        wr(`UDIS_OFF_CLEAR, A);
        fork
            wr(`UDIS_OFF_CLEAR, 32'h2);
            pulse(1);
        join
        rdc(`UDIS_OFF_STATUS, 32'h2, 32'h2);
        pulse(11);
        i_udis_host_model.wr(`UDIS_OFF_CLEAR, 32'h1000, 4'h1, r);
        rdc(`UDIS_OFF_STATUS, 32'h1000, 32'h1000);
        wr(`UDIS_OFF_CLEAR, A);
        rdc(`UDIS_OFF_STATUS, M, 32'h0);
        $display("test race done");
    endtask

    initial begin
        #(30000 * 8);
        errors++;
        give_verdict;
    end

    initial begin
        evt = '0;
        link = '0;
        vbus_pin = 1'b0;
        dp_pin = 1'b1;
        dm_pin = 1'b0;
        aresetn = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_events;
        t_link;
        t_irq;
        t_otg;
        t_pseudo_frame_flag;
        t_race;
        give_verdict;
    end
endmodule
